// ---- rtl/sramhc_ctrl.sv ----
`timescale 1ns/1ps
module sramhc_ctrl
  import sramhc_pkg::*;
(
  input  wire logic        SYS_CLK,          // 40 MHz clock
  input  wire logic        RST_N,            // Async reset, active low
  input  wire logic        REQ_VALID,        // Access request pulse or level
  input  wire logic        REQ_WRITE,        // 1 write, 0 read
  input  wire logic [7:0]  REQ_ADDR,         // Word address
  input  wire logic [3:0]  REQ_WDATA,        // Write data
  input  wire logic        COMMON_IO,        // 1 when data buses are shared
  input  wire logic        RETAIN_REQ,       // Ask for low supply retention
  output logic             REQ_READY,        // Idle, request will be taken
  output logic             RD_VALID,         // One-cycle read data strobe
  output logic [3:0]       RD_DATA,          // Read data
  output logic             RETAIN_OK,        // Supply may be lowered
  output logic             PRIMARY_SELECT_N, // Device primary select
  output logic             SECONDARY_SELECT, // Device secondary select
  output logic             OUTPUT_DISABLE,   // Device output disable
  output logic             WRITE_N,          // Device write strobe, active low
  output logic [7:0]       MEM_ADDR,         // Device address
  output logic [3:0]       MEM_DIN,          // Device data inputs
  input  wire logic [3:0]  MEM_DOUT          // Device data outputs
);
  sramhc_state_type state_ff;
  sramhc_state_type nxt_state;
  logic [3:0] dout_meta_ff;
  logic [3:0] dout_sync_ff;
  logic       retain_meta_ff;
  logic       retain_sync_ff;
  logic       tmr_load;
  logic [5:0] tmr_value;
  logic       tmr_done;

  // Timer for every phase; shared because phases never overlap
  sramhc_timer u_timer (
    .clk   (SYS_CLK),
    .rst_n (RST_N),
    .load  (tmr_load),
    .value (tmr_value),
    .done  (tmr_done)
  );

  // Read data and retention request come from outside; two flops each
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      dout_meta_ff   <= SRAMHC_DATA_ZERO;
      dout_sync_ff   <= SRAMHC_DATA_ZERO;
      retain_meta_ff <= 1'b0;
      retain_sync_ff <= 1'b0;
    end else begin
      dout_meta_ff   <= MEM_DOUT;
      dout_sync_ff   <= dout_meta_ff;
      retain_meta_ff <= RETAIN_REQ;
      retain_sync_ff <= retain_meta_ff;
    end
  end

  // Next state and timer loads
  always_comb begin
    nxt_state = state_ff;
    tmr_load  = 1'b0;
    tmr_value = SRAMHC_CNT_ZERO;
    case (state_ff)
      SRAMHC_IDLE: begin
        // A request already promised by ready is kept; retention waits a turn
        if (REQ_VALID && REQ_READY && REQ_WRITE) begin
          nxt_state = SRAMHC_WSETUP;
          tmr_load  = 1'b1;
          tmr_value = 6'(SRAMHC_AW_CYC);
        end else if (REQ_VALID && REQ_READY) begin
          nxt_state = SRAMHC_READ;
          tmr_load  = 1'b1;
          tmr_value = 6'(SRAMHC_RC_CYC);
        end else if (retain_sync_ff) begin
          nxt_state = SRAMHC_RETAIN;
          tmr_load  = 1'b1;
          tmr_value = 6'(SRAMHC_CDR_CYC);
        end
      end
      SRAMHC_READ: begin
        if (tmr_done) begin
          nxt_state = SRAMHC_IDLE;
        end
      end
      SRAMHC_WSETUP: begin
        if (tmr_done) begin
          nxt_state = SRAMHC_WPULSE;
          tmr_load  = 1'b1;
          tmr_value = 6'(SRAMHC_WP_CYC);
        end
      end
      SRAMHC_WPULSE: begin
        if (tmr_done) begin
          nxt_state = SRAMHC_WRECOV;
          tmr_load  = 1'b1;
          tmr_value = 6'(SRAMHC_WR_CYC);
        end
      end
      SRAMHC_WRECOV: begin
        if (tmr_done) begin
          nxt_state = SRAMHC_IDLE;
        end
      end
      SRAMHC_RETAIN: begin
        if (!retain_sync_ff) begin
          nxt_state = SRAMHC_RECOVER;
          tmr_load  = 1'b1;
          tmr_value = 6'(SRAMHC_RC_CYC);
        end
      end
      SRAMHC_RECOVER: begin
        if (tmr_done) begin
          nxt_state = SRAMHC_IDLE;
        end
      end
      default: begin
        nxt_state = SRAMHC_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_ff <= SRAMHC_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Address and write data latched on accept, held through the cycle
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      MEM_ADDR <= SRAMHC_ADDR_ZERO;
      MEM_DIN  <= SRAMHC_DATA_ZERO;
    end else if (state_ff == SRAMHC_IDLE && nxt_state != SRAMHC_IDLE
                 && nxt_state != SRAMHC_RETAIN) begin
      MEM_ADDR <= REQ_ADDR;
      MEM_DIN  <= REQ_WDATA;
    end
  end

  // Device control pins; selects only asserted inside an access
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      PRIMARY_SELECT_N <= 1'b1;
      SECONDARY_SELECT <= 1'b0;
      WRITE_N          <= 1'b1;
      OUTPUT_DISABLE   <= 1'b1;
    end else begin
      case (nxt_state)
        SRAMHC_READ: begin
          PRIMARY_SELECT_N <= 1'b0;
          SECONDARY_SELECT <= 1'b1;
          WRITE_N          <= 1'b1;
          OUTPUT_DISABLE   <= 1'b0;
        end
        SRAMHC_WSETUP, SRAMHC_WRECOV: begin
          PRIMARY_SELECT_N <= 1'b0;
          SECONDARY_SELECT <= 1'b1;
          WRITE_N          <= 1'b1;
          OUTPUT_DISABLE   <= COMMON_IO;
        end
        SRAMHC_WPULSE: begin
          PRIMARY_SELECT_N <= 1'b0;
          SECONDARY_SELECT <= 1'b1;
          WRITE_N          <= 1'b0;
          OUTPUT_DISABLE   <= COMMON_IO;
        end
        default: begin
          // Standby: the low secondary select gives least current
          PRIMARY_SELECT_N <= 1'b1;
          SECONDARY_SELECT <= 1'b0;
          WRITE_N          <= 1'b1;
          OUTPUT_DISABLE   <= COMMON_IO;
        end
      endcase
    end
  end

  // User-side status; retention granted only once deselected
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      REQ_READY <= 1'b0;
      RETAIN_OK <= 1'b0;
    end else begin
      REQ_READY <= (nxt_state == SRAMHC_IDLE) && !retain_sync_ff;
      RETAIN_OK <= (state_ff == SRAMHC_RETAIN) && tmr_done;
    end
  end

  // Read data sampled at the end of the read cycle, passed as is
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      RD_VALID <= 1'b0;
      RD_DATA  <= SRAMHC_DATA_ZERO;
    end else begin
      RD_VALID <= (state_ff == SRAMHC_READ) && tmr_done;
      if (state_ff == SRAMHC_READ && tmr_done) begin
        RD_DATA <= dout_sync_ff;
      end
    end
  end
endmodule

// ---- rtl/sramhc_pkg.sv ----
package sramhc_pkg;
  // Memory organisation
  localparam int          SRAMHC_ADDR_W     = 8;
  localparam int          SRAMHC_DATA_W     = 4;
  localparam int          SRAMHC_WORDS      = 256;
  // Clock rate and device timing (ns)
  localparam int          SRAMHC_CLK_NS     = 25;
  localparam int          SRAMHC_RC_NS      = 800;  // Read cycle, slowest grade
  localparam int          SRAMHC_WC_NS      = 800;  // Write cycle
  localparam int          SRAMHC_AW_NS      = 200;  // Address to write strobe
  localparam int          SRAMHC_WP_NS      = 450;  // Write pulse
  localparam int          SRAMHC_WR_NS      = 100;  // Write recovery
  localparam int          SRAMHC_CDR_NS     = 0;    // Deselect to retention
  // Cycle counts, least times rounded up; only the retention count is held to at least one
  localparam int          SRAMHC_RC_CYC     = (SRAMHC_RC_NS + SRAMHC_CLK_NS - 1) / SRAMHC_CLK_NS;
  localparam int          SRAMHC_AW_CYC     = (SRAMHC_AW_NS + SRAMHC_CLK_NS - 1) / SRAMHC_CLK_NS;
  localparam int          SRAMHC_WP_CYC     = (SRAMHC_WP_NS + SRAMHC_CLK_NS - 1) / SRAMHC_CLK_NS;
  localparam int          SRAMHC_WR_CYC     = (SRAMHC_WR_NS + SRAMHC_CLK_NS - 1) / SRAMHC_CLK_NS;
  localparam int          SRAMHC_CDR_RAW    = (SRAMHC_CDR_NS + SRAMHC_CLK_NS - 1) / SRAMHC_CLK_NS;
  localparam int          SRAMHC_CDR_CYC    = (SRAMHC_CDR_RAW < 1) ? 1 : SRAMHC_CDR_RAW;
  localparam int          SRAMHC_CNT_W      = 6;
  localparam logic [5:0]  SRAMHC_CNT_ZERO   = 6'h00;
  localparam logic [5:0]  SRAMHC_CNT_ONE    = 6'h01;
  localparam logic [3:0]  SRAMHC_DATA_ZERO  = 4'h0;
  localparam logic [7:0]  SRAMHC_ADDR_ZERO  = 8'h00;

  typedef enum logic [2:0] {
    SRAMHC_IDLE,
    SRAMHC_READ,
    SRAMHC_WSETUP,
    SRAMHC_WPULSE,
    SRAMHC_WRECOV,
    SRAMHC_RETAIN,
    SRAMHC_RECOVER
  } sramhc_state_type;
endpackage

// ---- rtl/sramhc_timer.sv ----
`timescale 1ns/1ps
// Down counter; done is high while the count has reached zero
module sramhc_timer
  import sramhc_pkg::*;
(
  input  wire logic        clk,      // System clock
  input  wire logic        rst_n,    // Async reset, active low
  input  wire logic        load,     // Load a new count
  input  wire logic [5:0]  value,    // Count to load
  output logic             done      // Count expired
);
  logic [5:0] count_ff;

  // Load wins over counting
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_ff <= SRAMHC_CNT_ZERO;
    end else if (load) begin
      count_ff <= value;
    end else if (count_ff != SRAMHC_CNT_ZERO) begin
      count_ff <= count_ff - SRAMHC_CNT_ONE;
    end
  end

  assign done = (count_ff == SRAMHC_CNT_ZERO);
endmodule

// ---- test/sramhc_ctrl_props.sv ----
`timescale 1ns/1ps
// Pin relations of the memory port controller
module sramhc_ctrl_props
  import sramhc_pkg::*;
(
  input wire logic SYS_CLK,          // Clock
  input wire logic RST_N,            // Reset
  input wire logic REQ_VALID,        // Request
  input wire logic REQ_WRITE,        // Kind
  input wire logic COMMON_IO,        // Shared bus
  input wire logic REQ_READY,        // Idle
  input wire logic RD_VALID,         // Read strobe
  input wire logic RETAIN_OK,        // Retention
  input wire logic PRIMARY_SELECT_N, // Select
  input wire logic SECONDARY_SELECT, // Select
  input wire logic OUTPUT_DISABLE,   // Output disable
  input wire logic WRITE_N           // Strobe
);
  default clocking dc @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  // Strobe only inside a full selection
  a_write_sel: assert property (!WRITE_N |-> !PRIMARY_SELECT_N && SECONDARY_SELECT)
    else $error("strobe without selects");
  a_idle_standby: assert property (REQ_READY |-> !SECONDARY_SELECT && PRIMARY_SELECT_N)
    else $error("idle but selected");
  a_write_od: assert property (!WRITE_N && COMMON_IO |-> OUTPUT_DISABLE)
    else $error("outputs enabled in shared write");
  a_idle_od: assert property (REQ_READY && $stable(COMMON_IO) |-> OUTPUT_DISABLE == COMMON_IO)
    else $error("idle disable level wrong");
  a_retain_desel: assert property (RETAIN_OK |-> PRIMARY_SELECT_N && !SECONDARY_SELECT)
    else $error("retention while selected");
  a_rd_pulse: assert property (RD_VALID |=> !RD_VALID)
    else $error("read strobe too long");
  a_read_lat: assert property (REQ_READY && REQ_VALID && !REQ_WRITE |-> ##34 RD_VALID)
    else $error("read answer late");
  // Strobe stays low for the pulse count plus the cycle the timer sits at zero
  a_strobe_len: assert property ($fell(WRITE_N) |-> !WRITE_N [*8] ##12 $rose(WRITE_N))
    else $error("write pulse length wrong");
  a_addr_setup: assert property ($fell(WRITE_N) |-> $past(SECONDARY_SELECT, 8))
    else $error("write setup too short");
  c_read: cover property (RD_VALID);
  c_write: cover property ($fell(WRITE_N) && COMMON_IO);
  c_retain: cover property ($rose(RETAIN_OK));
endmodule
bind sramhc_ctrl sramhc_ctrl_props u_sramhc_ctrl_props (
  .SYS_CLK          (SYS_CLK),
  .RST_N            (RST_N),
  .REQ_VALID        (REQ_VALID),
  .REQ_WRITE        (REQ_WRITE),
  .COMMON_IO        (COMMON_IO),
  .REQ_READY        (REQ_READY),
  .RD_VALID         (RD_VALID),
  .RETAIN_OK        (RETAIN_OK),
  .PRIMARY_SELECT_N (PRIMARY_SELECT_N),
  .SECONDARY_SELECT (SECONDARY_SELECT),
  .OUTPUT_DISABLE   (OUTPUT_DISABLE),
  .WRITE_N          (WRITE_N)
);

// ---- test/sramhc_ctrl_tb.sv ----
`timescale 1ns/1ps
// Directed bench for the memory port controller
module sramhc_ctrl_tb;
  import sramhc_pkg::*;
  logic       clk, rst_n, vld, wr, cio, ret, rdy, rv, rok, psn, ss, od, wn;
  logic [7:0] addr, maddr;
  logic [3:0] wd, rd, din, dout;
  int         err_total = 0;
  int         samples_checked = 0;
  int         n;
  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  sramhc_ctrl u_sramhc_ctrl (.SYS_CLK(clk), .RST_N(rst_n), .REQ_VALID(vld), .REQ_WRITE(wr),
    .REQ_ADDR(addr), .REQ_WDATA(wd), .COMMON_IO(cio), .RETAIN_REQ(ret), .REQ_READY(rdy),
    .RD_VALID(rv), .RD_DATA(rd), .RETAIN_OK(rok), .PRIMARY_SELECT_N(psn),
    .SECONDARY_SELECT(ss), .OUTPUT_DISABLE(od), .WRITE_N(wn), .MEM_ADDR(maddr),
    .MEM_DIN(din), .MEM_DOUT(dout));
  sramhc_mem_model u_sramhc_mem_model (.psel_n(psn), .ssel(ss), .od(od), .we_n(wn),
    .addr(maddr), .din(din), .dout(dout));
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(string name, logic [3:0] exp, logic [3:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Bounded wait at falling edges; a hang ends the run
  task automatic wait_hi(ref logic s, input int lim);
    n = 0;
    while (s !== 1'b1) begin
      if (n == lim) begin
        err_total++;
        test_done();
      end
      @(negedge clk);
      n++;
    end
  endtask
  // Hold the request through the edge that takes it
  task automatic req(logic w, logic [7:0] a, logic [3:0] d);
    @(negedge clk);
    vld = 1;
    wr = w;
    addr = a;
    wd = d;
    wait_hi(rdy, 200);
    @(negedge clk);
    vld = 0;
  endtask
  task automatic rd_chk(logic [7:0] a, logic [3:0] exp);
    req(0, a, 4'h0);
    wait_hi(rv, 60);
    chk("read data", exp, rd);
  endtask
  task automatic t_reset();
    chk("idle pins", 4'hD, {rdy, psn, ss, wn});
    chk("idle disable", 4'h0, {3'h0, od});
  endtask
  task automatic t_sep();
    req(1, 8'h00, 4'hA);
    req(1, 8'hFF, 4'h5);
    req(1, 8'h80, 4'h3);
    req(1, 8'h01, 4'hC);
    rd_chk(8'h00, 4'hA);
    rd_chk(8'hFF, 4'h5);
    rd_chk(8'hFF, 4'h5);
    rd_chk(8'h80, 4'h3);
    rd_chk(8'h01, 4'hC);
  endtask
  // Mid-pulse look at the pins, then idle with the shared bus still set
  task automatic t_common();
    @(negedge clk);
    cio = 1;
    req(1, 8'h3C, 4'h9);
    repeat (12) @(negedge clk);
    chk("shared write disable", 4'h1, {3'h0, od});
    chk("shared write strobe", 4'h0, {3'h0, wn});
    rd_chk(8'h3C, 4'h9);
    chk("shared idle disable", 4'h1, {3'h0, od});
    cio = 0;
  endtask
  // A request held while busy must be ignored, not queued
  task automatic t_refused();
    req(1, 8'h3C, 4'h6);
    @(negedge clk);
    vld = 1;
    wd = 4'hF;
    repeat (5) @(negedge clk);
    chk("busy ready", 4'h0, {3'h0, rdy});
    vld = 0;
    rd_chk(8'h3C, 4'h6);
  endtask
  task automatic t_retain();
    wait_hi(rdy, 200);
    ret = 1;
    wait_hi(rok, 20);
    chk("retain pins", 4'h5, {rdy, psn, ss, wn});
    ret = 0;
    wait_hi(rdy, 100);
    chk("recovery wait", 4'h1, {3'h0, n >= SRAMHC_RC_CYC});
    rd_chk(8'hFF, 4'h5);
  endtask
  initial begin
    rst_n = 0;
    vld = 0;
    wr = 0;
    cio = 0;
    ret = 0;
    addr = 8'h00;
    wd = 4'h0;
    repeat (20) @(negedge clk);
    rst_n = 1;
    repeat (2) @(negedge clk);
    t_reset();
    t_sep();
    t_common();
    t_refused();
    t_retain();
    test_done();
  end
endmodule

// ---- test/sramhc_mem_model.sv ----
`timescale 1ns/1ps
// 256 x 4 static memory on the controller's far side
module sramhc_mem_model
  import sramhc_pkg::*;
(
  input  wire logic       psel_n, // Primary select, low
  input  wire logic       ssel,   // Secondary select
  input  wire logic       od,     // Output disable
  input  wire logic       we_n,   // Write strobe, low
  input  wire logic [7:0] addr,   // Address
  input  wire logic [3:0] din,    // Data in
  output logic      [3:0] dout    // Data out
);
  logic [3:0] mem [SRAMHC_WORDS];
  logic [3:0] last = 4'h0;
  wire        sel = !psel_n && ssel;
  // Store at strobe end, while the address is still held
  always @(posedge we_n) if (sel) mem[addr] = din;
  // Floating outputs show the inverse, so a stale word never matches
  always @* begin
    if (sel && !od) dout = mem[addr];
    else dout = ~last;
  end
  always @(dout) if (sel && !od) last = dout;
endmodule
